// *** logic/phm_mmd_bank.sv ***
module phm_mmd_bank
  import phm_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        ledStyleStrap,
  input  wire logic [4:0]  devAd,
  input  wire logic [15:0] regAddr,
  input  wire logic        wrEn,
  input  wire logic [15:0] wrData,
  output logic      [15:0] rdData,
  output logic      [15:0] flpBurstLow,
  output logic      [15:0] flpBurstHigh,
  output logic      [2:0]  linkUpTime,
  output logic             ledSingleMode
);
  import phm_pkg::*;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  logic hitLow;
  logic hitHigh;
  logic hitLink;
  logic hitCommon;

  assign hitLow    = (devAd == PHM_DEV_AN) && (regAddr == PHM_REG_FLP_LOW);
  assign hitHigh   = (devAd == PHM_DEV_AN) && (regAddr == PHM_REG_FLP_HIGH);
  assign hitLink   = (devAd == PHM_DEV_PMA) && (regAddr == PHM_REG_LINK_UP);
  assign hitCommon = (devAd == PHM_DEV_VEND) && (regAddr == PHM_REG_COMMON);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [15:0] flpLow_q;
  logic [15:0] flpHigh_q;
  logic [8:0]  linkUp_q;
  logic [10:0] ccRsvd_q;
  logic        ccRsvd2_q;
  logic        ledStyle_q;
  logic        strapTaken_q;

  // software is trusted to keep both halves on the same code
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      flpLow_q  <= PHM_FLP_LOW_RST;
      flpHigh_q <= PHM_FLP_HIGH_RST;
    end else if (wrEn && hitLow) begin
      flpLow_q <= wrData;
    end else if (wrEn && hitHigh) begin
      flpHigh_q <= wrData;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      linkUp_q <= PHM_LINK_UP_RST;
    end else if (wrEn && hitLink) begin
      linkUp_q <= wrData[PHM_LINK_UP_MSB:0];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ccRsvd_q  <= PHM_CC_RSVD_RST;
      ccRsvd2_q <= 1'b0;
    end else if (wrEn && hitCommon) begin
      ccRsvd_q  <= wrData[PHM_CC_RSVD_MSB:PHM_CC_RSVD_LSB];
      ccRsvd2_q <= wrData[PHM_CC_RSVD2];
    end
  end

  // strap is caught on the first edge after release, not by the reset itself
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      strapTaken_q <= 1'b0;
      ledStyle_q   <= 1'b0;
    end else if (!strapTaken_q) begin
      strapTaken_q <= 1'b1;
      ledStyle_q   <= ledStyleStrap;
    end else if (wrEn && hitCommon) begin
      ledStyle_q <= wrData[PHM_CC_LED_OVR];
    end
  end

  // ----------------------------------------
  // read mux, unmapped reads return zero
  // ----------------------------------------
  always_comb begin
    rdData = 16'h0000;
    if (hitLow) begin
      rdData = flpLow_q;
    end else if (hitHigh) begin
      rdData = flpHigh_q;
    end else if (hitLink) begin
      rdData[PHM_LINK_UP_MSB:0] = linkUp_q;
    end else if (hitCommon) begin
      rdData[PHM_CC_RSVD_MSB:PHM_CC_RSVD_LSB] = ccRsvd_q;
      rdData[PHM_CC_LED_OVR]  = 1'b0;
      rdData[PHM_CC_LED_STAT] = ledStyle_q;
      rdData[PHM_CC_RSVD2]    = ccRsvd2_q;
    end
  end

  assign flpBurstLow   = flpLow_q;
  assign flpBurstHigh  = flpHigh_q;
  assign linkUpTime    = linkUp_q[PHM_LUT_MSB:PHM_LUT_LSB];
  assign ledSingleMode = ledStyle_q;
endmodule

// *** logic/phm_mmd_portal.sv ***
module phm_mmd_portal
  import phm_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        ledStyleStrap,
  input  wire logic        mgmtWrEn,
  input  wire logic        mgmtRdEn,
  input  wire logic [4:0]  mgmtRegAddr,
  input  wire logic [15:0] mgmtWrData,
  output logic      [15:0] mgmtRdData,
  output logic             mgmtRdValid,
  output logic      [15:0] flpBurstLow,
  output logic      [15:0] flpBurstHigh,
  output logic      [2:0]  linkUpTime,
  output logic             ledSingleMode
);
  import phm_pkg::*;

  // ----------------------------------------
  // portal registers
  // ----------------------------------------
  logic [15:0] ctrl_q;
  logic [15:0] mmdAddr_q;
  logic [15:0] mmdAddr_d;
  logic [1:0]  mode;
  logic [4:0]  devAd;
  logic        ctrlHit;
  logic        dataHit;
  logic        dataWr;
  logic        dataRd;
  logic [15:0] bankRdData;

  assign mode    = ctrl_q[PHM_MODE_MSB:PHM_MODE_LSB];
  assign devAd   = ctrl_q[PHM_DEVAD_MSB:0];
  assign ctrlHit = (mgmtRegAddr == PHM_PORTAL_CTRL);
  assign dataHit = (mgmtRegAddr == PHM_PORTAL_DATA);
  assign dataWr  = mgmtWrEn && dataHit && (mode != PHM_MODE_ADDR);
  assign dataRd  = mgmtRdEn && dataHit && (mode != PHM_MODE_ADDR);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= PHM_CTRL_RST;
    end else if (mgmtWrEn && ctrlHit) begin
      ctrl_q <= mgmtWrData;
    end
  end

  // one shared address register; a write outranks a same-cycle read
  always_comb begin
    mmdAddr_d = mmdAddr_q;
    if (mgmtWrEn && dataHit) begin
      unique case (mode)
        PHM_MODE_ADDR:      mmdAddr_d = mgmtWrData;
        PHM_MODE_DATA:      mmdAddr_d = mmdAddr_q;
        PHM_MODE_DATA_INC,
        PHM_MODE_DATA_INCW: mmdAddr_d = mmdAddr_q + 16'h0001;
      endcase
    end else if (dataRd && (mode == PHM_MODE_DATA_INC)) begin
      mmdAddr_d = mmdAddr_q + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mmdAddr_q <= PHM_ADDR_RST;
    end else begin
      mmdAddr_q <= mmdAddr_d;
    end
  end

  // ----------------------------------------
  // read answer, one cycle after the strobe
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mgmtRdData <= 16'h0000;
    end else if (mgmtRdEn) begin
      if (ctrlHit) begin
        mgmtRdData <= ctrl_q;
      end else if (dataHit && (mode == PHM_MODE_ADDR)) begin
        mgmtRdData <= mmdAddr_q;
      end else if (dataHit) begin
        mgmtRdData <= bankRdData;
      end else begin
        mgmtRdData <= 16'h0000;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mgmtRdValid <= 1'b0;
    end else begin
      mgmtRdValid <= mgmtRdEn;
    end
  end

  // ----------------------------------------
  // indirect register bank
  // ----------------------------------------
  phm_mmd_bank uBank (
    .sys_clk       (sys_clk),
    .nrst          (nrst),
    .ledStyleStrap (ledStyleStrap),
    .devAd         (devAd),
    .regAddr       (mmdAddr_q),
    .wrEn          (dataWr),
    .wrData        (mgmtWrData),
    .rdData        (bankRdData),
    .flpBurstLow   (flpBurstLow),
    .flpBurstHigh  (flpBurstHigh),
    .linkUpTime    (linkUpTime),
    .ledSingleMode (ledSingleMode)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic firstDone_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      firstDone_q <= 1'b0;
    end else begin
      firstDone_q <= 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_flp_low_reset: assert property (
    !firstDone_q |-> flpBurstLow == PHM_FLP_LOW_RST)
    else $error("burst timing low half not at reset value");

  a_flp_high_reset: assert property (
    !firstDone_q |-> flpBurstHigh == PHM_FLP_HIGH_RST)
    else $error("burst timing high half not at reset value");

  a_link_up_reset: assert property (
    !firstDone_q |-> linkUpTime == PHM_LINK_UP_RST[PHM_LUT_MSB:PHM_LUT_LSB])
    else $error("link-up time not at reset value");

  a_override_reads_zero: assert property (
    mgmtRdEn && dataRd && devAd == PHM_DEV_VEND && mmdAddr_q == PHM_REG_COMMON
    |=> mgmtRdValid && !mgmtRdData[PHM_CC_LED_OVR])
    else $error("led override bit read back nonzero");

  a_led_strap_taken: assert property (
    !firstDone_q ##1 1'b1 |-> ledSingleMode == $past(ledStyleStrap))
    else $error("led status did not take strap value");

  a_led_override_write: assert property (
    firstDone_q && dataWr && devAd == PHM_DEV_VEND && mmdAddr_q == PHM_REG_COMMON
    |=> ledSingleMode == $past(mgmtWrData[PHM_CC_LED_OVR]))
    else $error("led override write not reflected");

  a_led_status_read: assert property (
    mgmtRdEn && dataRd && devAd == PHM_DEV_VEND && mmdAddr_q == PHM_REG_COMMON
    |=> mgmtRdData[PHM_CC_LED_STAT] == $past(ledSingleMode))
    else $error("led status bit disagrees with led style output");

  a_link_up_stable: assert property (
    !(dataWr && devAd == PHM_DEV_PMA) |=> $stable(linkUpTime))
    else $error("link-up time changed without a write");

  a_addr_inc_write: assert property (
    mgmtWrEn && dataHit && mode[1] |=> mmdAddr_q == $past(mmdAddr_q) + 16'h0001)
    else $error("address did not advance after data write");

  a_addr_hold: assert property (
    (mgmtRdEn && dataHit && mode == PHM_MODE_DATA_INCW && !mgmtWrEn)
    or (mgmtWrEn && dataHit && mode == PHM_MODE_DATA)
    |=> $stable(mmdAddr_q))
    else $error("address moved in a non-incrementing access");
endmodule

// *** logic/phm_pkg.sv ***
package phm_pkg;
  // portal registers of the management register space
  localparam logic [4:0]  PHM_PORTAL_CTRL    = 5'h0d;
  localparam logic [4:0]  PHM_PORTAL_DATA    = 5'h0e;
  // portal control fields
  localparam int          PHM_MODE_MSB       = 15;
  localparam int          PHM_MODE_LSB       = 14;
  localparam int          PHM_DEVAD_MSB      = 4;
  localparam logic [15:0] PHM_CTRL_RST       = 16'h0000;
  localparam logic [15:0] PHM_ADDR_RST       = 16'h0000;
  localparam logic [1:0]  PHM_MODE_ADDR      = 2'h0;
  localparam logic [1:0]  PHM_MODE_DATA      = 2'h1;
  localparam logic [1:0]  PHM_MODE_DATA_INC  = 2'h2;
  localparam logic [1:0]  PHM_MODE_DATA_INCW = 2'h3;
  // device addresses and register offsets
  localparam logic [4:0]  PHM_DEV_AN         = 5'h00;
  localparam logic [4:0]  PHM_DEV_PMA        = 5'h01;
  localparam logic [4:0]  PHM_DEV_VEND       = 5'h02;
  localparam logic [15:0] PHM_REG_FLP_LOW    = 16'h0003;
  localparam logic [15:0] PHM_REG_FLP_HIGH   = 16'h0004;
  localparam logic [15:0] PHM_REG_LINK_UP    = 16'h005a;
  localparam logic [15:0] PHM_REG_COMMON     = 16'h0000;
  // reset values and codes
  localparam logic [15:0] PHM_FLP_LOW_RST    = 16'h4000;
  localparam logic [15:0] PHM_FLP_LOW_16MS   = 16'h1a80;
  localparam logic [15:0] PHM_FLP_HIGH_RST   = 16'h0003;
  localparam logic [15:0] PHM_FLP_HIGH_16MS  = 16'h0006;
  localparam logic [8:0]  PHM_LINK_UP_RST    = 9'h108;
  localparam int          PHM_LINK_UP_MSB    = 8;
  localparam int          PHM_LUT_MSB        = 3;
  localparam int          PHM_LUT_LSB        = 1;
  // common control fields
  localparam int          PHM_CC_RSVD_MSB    = 15;
  localparam int          PHM_CC_RSVD_LSB    = 5;
  localparam int          PHM_CC_LED_OVR     = 4;
  localparam int          PHM_CC_LED_STAT    = 3;
  localparam int          PHM_CC_RSVD2       = 2;
  localparam logic [10:0] PHM_CC_RSVD_RST    = 11'h000;
  localparam logic        PHM_LED_SINGLE     = 1'b1;
endpackage

// *** sim/phm_mgmt_model.sv ***
// -------------------------------------------
// management station model, drives the portal
// -------------------------------------------
module phm_mgmt_model
  import phm_pkg::*;
(
  input  wire logic        sys_clk,
  output logic             mgmtWrEn,
  output logic             mgmtRdEn,
  output logic      [4:0]  mgmtRegAddr,
  output logic      [15:0] mgmtWrData,
  input  wire logic [15:0] mgmtRdData,
  input  wire logic        mgmtRdValid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    mgmtWrEn    = 1'b0;
    mgmtRdEn    = 1'b0;
    mgmtRegAddr = 5'h1f;
    mgmtWrData  = 16'hffff;
  end

  // idle lines carry inverted junk so stale values never match by luck
  task automatic acc(input logic wr, input logic [4:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    mgmtWrEn    = wr;
    mgmtRdEn    = !wr;
    mgmtRegAddr = a;
    mgmtWrData  = d;
    @(negedge sys_clk);
    mgmtWrEn    = 1'b0;
    mgmtRdEn    = 1'b0;
    mgmtRegAddr = ~a;
    mgmtWrData  = ~d;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    acc(1'b1, a, d);
  endtask

  // valid stands only from the strobe edge to the next, so sample right away
  task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic v);
    acc(1'b0, a, 16'h0000);
    v = mgmtRdValid;
    d = mgmtRdData;
  endtask

  task automatic sel(input logic [4:0] dev, input logic [15:0] r, input logic [1:0] m);
    wr(PHM_PORTAL_CTRL, {PHM_MODE_ADDR, 9'h000, dev});
    wr(PHM_PORTAL_DATA, r);
    wr(PHM_PORTAL_CTRL, {m, 9'h000, dev});
  endtask
endmodule

// *** sim/tb_top.sv ***
// -------------------------------------------
// portal register bench
// -------------------------------------------
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import phm_pkg::*;

  logic        sys_clk, nrst, ledStyleStrap, mgmtWrEn, mgmtRdEn, mgmtRdValid;
  logic        ledSingleMode, vld;
  logic [4:0]  mgmtRegAddr;
  logic [15:0] mgmtWrData, mgmtRdData, flpBurstLow, flpBurstHigh, rd;
  logic [2:0]  linkUpTime;
  int          mismatches, testsRun;

  phm_mmd_portal dut (
    .sys_clk(sys_clk), .nrst(nrst), .ledStyleStrap(ledStyleStrap),
    .mgmtWrEn(mgmtWrEn), .mgmtRdEn(mgmtRdEn), .mgmtRegAddr(mgmtRegAddr),
    .mgmtWrData(mgmtWrData), .mgmtRdData(mgmtRdData), .mgmtRdValid(mgmtRdValid),
    .flpBurstLow(flpBurstLow), .flpBurstHigh(flpBurstHigh),
    .linkUpTime(linkUpTime), .ledSingleMode(ledSingleMode)
  );

  phm_mgmt_model mgmt (
    .sys_clk(sys_clk), .mgmtWrEn(mgmtWrEn), .mgmtRdEn(mgmtRdEn),
    .mgmtRegAddr(mgmtRegAddr), .mgmtWrData(mgmtWrData),
    .mgmtRdData(mgmtRdData), .mgmtRdValid(mgmtRdValid)
  );

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdchk(input logic [15:0] exp);
    mgmt.rd(PHM_PORTAL_DATA, rd, vld);
    chk({15'h0, vld}, 16'h0001);
    chk(rd, exp);
  endtask

  task automatic t_reset();
    chk(flpBurstLow, 16'h4000);
    chk(flpBurstHigh, 16'h0003);
    chk({13'h0, linkUpTime}, 16'h0004);
    chk({15'h0, ledSingleMode}, 16'h0001);
    mgmt.sel(PHM_DEV_PMA, PHM_REG_LINK_UP, PHM_MODE_DATA);
    rdchk(16'h0108);
    mgmt.sel(PHM_DEV_VEND, PHM_REG_COMMON, PHM_MODE_DATA);
    rdchk(16'h0008);
    mgmt.rd(5'h00, rd, vld);
    chk(rd, 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_flp();
    mgmt.sel(PHM_DEV_AN, PHM_REG_FLP_LOW, PHM_MODE_DATA_INCW);
    mgmt.wr(PHM_PORTAL_DATA, 16'h1a80);
    mgmt.wr(PHM_PORTAL_DATA, 16'h0006);
    chk(flpBurstLow, 16'h1a80);
    chk(flpBurstHigh, 16'h0006);
    mgmt.sel(PHM_DEV_AN, PHM_REG_FLP_LOW, PHM_MODE_DATA_INC);
    rdchk(16'h1a80);
    rdchk(16'h0006);
    mgmt.sel(PHM_DEV_AN, PHM_REG_FLP_HIGH, PHM_MODE_DATA_INCW);
    rdchk(16'h0006);
    rdchk(16'h0006);
    mgmt.wr(PHM_PORTAL_CTRL, {PHM_MODE_ADDR, 9'h000, PHM_DEV_AN});
    rdchk(16'h0004);
    $display("test burst timing done");
  endtask

  task automatic t_led();
    mgmt.sel(PHM_DEV_VEND, PHM_REG_COMMON, PHM_MODE_DATA);
    mgmt.wr(PHM_PORTAL_DATA, 16'h0000);
    chk({15'h0, ledSingleMode}, 16'h0000);
    rdchk(16'h0000);
    mgmt.wr(PHM_PORTAL_DATA, 16'h8014);
    chk({15'h0, ledSingleMode}, 16'h0001);
    rdchk(16'h800c);
    $display("test led style done");
  endtask

  task automatic t_link();
    mgmt.sel(PHM_DEV_PMA, PHM_REG_LINK_UP, PHM_MODE_DATA);
    mgmt.wr(PHM_PORTAL_DATA, 16'hfe0a);
    chk({13'h0, linkUpTime}, 16'h0005);
    rdchk(16'h000a);
    $display("test link-up time done");
  endtask

  // second reset with the strap now low
  task automatic t_rerst();
    @(negedge sys_clk);
    nrst = 1'b0;
    @(negedge sys_clk);
    chk(flpBurstLow, 16'h4000);
    chk(flpBurstHigh, 16'h0003);
    chk({13'h0, linkUpTime}, 16'h0004);
    nrst = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk({15'h0, ledSingleMode}, 16'h0000);
    // a strap move after the capture edge must not reach the status
    ledStyleStrap = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk({15'h0, ledSingleMode}, 16'h0000);
    $display("test second reset done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    #100000;
    mismatches++;
    final_report();
  end

  initial begin
    nrst          = 1'b0;
    ledStyleStrap = 1'b1;
    mismatches    = 0;
    testsRun      = 0;
    repeat (6) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (2) @(negedge sys_clk);
    // strap is captured once; later moves must not show
    ledStyleStrap = 1'b0;
    t_reset();
    t_flp();
    t_led();
    t_link();
    t_rerst();
    final_report();
  end
endmodule
